// [core/mcst_regs.svh]
// Bit positions, codes and reset values for the self-test word and check control
`ifndef MCST_REGS_SVH
`define MCST_REGS_SVH
`define MCST_HEALTH_LSB      0
`define MCST_HEALTH_MSB      1
`define MCST_TESTED_BIT      2
`define MCST_VM_BIT          16
`define MCST_X86_BIT         17
`define MCST_FP_BIT          18
`define MCST_MISC_BIT        19
`define MCST_DETAIL_LSB      32
`define MCST_DETAIL_MSB      63
`define MCST_HEALTH_OK       2'h0
`define MCST_HEALTH_PERF     2'h1
`define MCST_HEALTH_FUNC     2'h2
`define MCST_MISSING_CODE    32'hffff_ffff
`define MCST_RESULT_RST      64'h0
`define MCST_PTR_RST         64'h0
`define MCST_SCRATCH_N       3
`endif

// [core/mcst_pkg.sv]
// Types shared by the self-test and machine-check logic
package mcst_pkg;
  typedef struct packed {
    logic        done;
    logic        catastrophic;
    logic        perf_degraded;
    logic        vm_fail;
    logic        x86_fail;
    logic        fp_fail;
    logic        misc_fail;
    logic [31:0] detail;
  } mcst_test_t;

  typedef struct packed {
    logic [63:0] ip;
    logic [63:0] status;
    logic [63:0] frame;
  } mcst_ctx_t;

  typedef enum logic [1:0] {
    MCST_IDLE,
    MCST_IN_HANDLER,
    MCST_AT_FIRMWARE
  } mcst_state_t;
endpackage

// [core/mcst_result_word.sv]
// Packs the self-test outcome into the 64-bit result word
`timescale 1ns/1ps
`include "mcst_regs.svh"
module mcst_result_word (
  input  mcst_pkg::mcst_test_t test,
  output logic [63:0]          word,
  output logic                 halt
);
  logic [1:0] health;

  // Functional impairment outranks performance loss
  always_comb begin
    if (test.vm_fail || test.x86_fail || test.fp_fail || test.misc_fail) begin
      health = `MCST_HEALTH_FUNC;
    end else if (test.perf_degraded) begin
      health = `MCST_HEALTH_PERF;
    end else begin
      health = `MCST_HEALTH_OK;
    end
  end

  // Reserved bits stay zero; untested word carries only a zero tested flag
  always_comb begin
    word = `MCST_RESULT_RST;
    halt = test.done && test.catastrophic;
    if (test.done) begin
      word[`MCST_HEALTH_MSB:`MCST_HEALTH_LSB] = health;
      word[`MCST_TESTED_BIT] = 1'b1;
      if (health == `MCST_HEALTH_FUNC) begin
        word[`MCST_VM_BIT]   = test.vm_fail;
        word[`MCST_X86_BIT]  = test.x86_fail;
        word[`MCST_FP_BIT]   = test.fp_fail;
        word[`MCST_MISC_BIT] = test.misc_fail;
      end
      if (health != `MCST_HEALTH_OK) begin
        word[`MCST_DETAIL_MSB:`MCST_DETAIL_LSB] = test.detail;
      end
    end
  end
endmodule

// [core/mcst_scratch_bank.sv]
// One preserved scratch register, loaded on command
`timescale 1ns/1ps
module mcst_scratch_bank #(
  parameter int W = 64
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  // Holds its value across a check until firmware reloads it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dout <= '0;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule

// [core/mcst_core.sv]
// Self-test result reporting and machine-check handler entry control
`timescale 1ns/1ps
`include "mcst_regs.svh"
// Functional notes
// - Health field 00 healthy, 01 performance degraded, 10 functionally impaired.
// - Catastrophic self-test failure halts; never reaches platform firmware entry; here a handler already running still advances to firmware.
// - Tested flag zero means every other result field is invalid.
// - Under functional impairment, per-unit unavailability flags are set.
// - 32-bit detail word meaningful only for degraded or impaired health.
// - Failing component is isolated before impairment is reported; here unit_isolate and result_word load on the same edge.
// - Impaired device keeps core units working; floating point may be disabled.
// - Enter handler on a check while the mask bit is zero.
// - Masked check stays pending; enter handler when mask goes 1 to 0.
// - Hardware sets mask on entry; it stays set into platform firmware.
// - Log state at error time; missing information gets a marker code.
// - Repeated signalling of one error is logged as a single error.
// - Expected checks are logged but recovery is skipped.
// - Handler always tries to reach platform firmware unless execution impossible.
// - A second check during handling is held, not lost.
// - Dedicated register holds the save area pointer.
// - Bank-zero registers 24 to 31 are scratch for recovery code.
// - Optional capture of ip, status, frame, with a restoring return.
// - Optional three scratch registers preserve bank-zero 24 to 31.
// - Floating-point failure under impairment sets both float disable bits.
module mcst_core #(
  parameter bit HAS_CTX_COPY = 1'b1,
  parameter bit HAS_SCRATCH  = 1'b1
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire mcst_pkg::mcst_test_t test_in,
  input  wire logic                 test_valid,
  input  wire logic                 check_event,
  input  wire logic [31:0]          check_error_id,
  input  wire logic                 check_info_valid,
  input  wire logic [31:0]          check_info,
  input  wire mcst_pkg::mcst_ctx_t  live_ctx,
  input  wire logic                 expected_check_call,
  input  wire logic                 mask_clear,
  input  wire logic                 firmware_handoff,
  input  wire logic                 exec_possible,
  input  wire logic                 save_ptr_we,
  input  wire logic [63:0]          save_ptr_wdata,
  input  wire logic [2:0]           scratch_we,
  input  wire logic [63:0]          scratch_wdata,
  input  wire logic                 ctx_return,
  input  wire logic                 interruption_collection_enable,
  output logic [63:0]               result_word,
  output logic                      core_halted,
  output logic                      float_low_disable,
  output logic                      float_high_disable,
  output logic [4:0]                unit_isolate,
  output logic                      machine_check_mask,
  output logic                      machine_check_handler_entry,
  output logic                      check_pending,
  output logic                      in_handler,
  output logic                      at_firmware,
  output logic                      recovery_enable,
  output logic [31:0]               logged_error_id,
  output logic [31:0]               logged_info,
  output logic                      nested_check,
  output logic [63:0]               save_area_pointer,
  output mcst_pkg::mcst_ctx_t       check_ctx_copy,
  output logic                      ctx_restore,
  output logic [191:0]              check_scratch_regs,
  output logic                      recovery_ready
);
  mcst_pkg::mcst_state_t state_q;
  logic [63:0]           word_d;
  logic                  halt_d;
  logic                  enter_d;
  logic                  duplicate;
  logic                  expected_q;
  logic                  mask_q;
  logic                  pend_q;
  // Details of a held check, captured when it occurs so that its later entry logs error-time state
  logic [31:0]           pend_id_q;
  logic [31:0]           pend_info_q;
  mcst_pkg::mcst_ctx_t   pend_ctx_q;

  mcst_result_word u_word (
    .test (test_in),
    .word (word_d),
    .halt (halt_d)
  );

  // Result word and unit isolation captured when self-test finishes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      result_word  <= `MCST_RESULT_RST;
      core_halted  <= 1'b0;
      unit_isolate <= 5'h0;
    end else if (test_valid) begin
      result_word  <= word_d;
      core_halted  <= halt_d;
      // Failing units cut off; ALU, shifter, branch and memory paths untouched
      unit_isolate <= {word_d[`MCST_MISC_BIT], word_d[`MCST_FP_BIT],
                       word_d[`MCST_X86_BIT], word_d[`MCST_VM_BIT], 1'b0};
    end
  end

  // Float register disables follow a float failure under impairment
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      float_low_disable  <= 1'b0;
      float_high_disable <= 1'b0;
    end else if (test_valid) begin
      float_low_disable  <= word_d[`MCST_FP_BIT];
      float_high_disable <= word_d[`MCST_FP_BIT];
    end
  end

  // A check entering while mask clear, or a pending one released by mask clear;
  // the release comes from the firmware stage, so it must not wait for idle
  assign enter_d = !core_halted &&
                   ((state_q == mcst_pkg::MCST_IDLE && check_event && !mask_q) ||
                    (pend_q && mask_clear && state_q != mcst_pkg::MCST_IN_HANDLER));
  // Same error id while already logged counts as one signalling
  assign duplicate = check_event && state_q != mcst_pkg::MCST_IDLE &&
                     check_error_id == logged_error_id;

  // Handler progress; halting only blocks new entry, a handler already running still advances
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= mcst_pkg::MCST_IDLE;
    end else begin
      unique case (state_q)
        mcst_pkg::MCST_IDLE: begin
          if (enter_d) begin
            state_q <= mcst_pkg::MCST_IN_HANDLER;
          end
        end
        mcst_pkg::MCST_IN_HANDLER: begin
          if (firmware_handoff && exec_possible) begin
            state_q <= mcst_pkg::MCST_AT_FIRMWARE;
          end
        end
        mcst_pkg::MCST_AT_FIRMWARE: begin
          if (enter_d) begin
            state_q <= mcst_pkg::MCST_IN_HANDLER;
          end else if (mask_clear) begin
            state_q <= mcst_pkg::MCST_IDLE;
          end
        end
      endcase
    end
  end

  // Mask set by hardware on entry, cleared only by firmware from firmware stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_q <= 1'b0;
    end else if (enter_d) begin
      mask_q <= 1'b1;
    end else if (mask_clear && state_q != mcst_pkg::MCST_IN_HANDLER) begin
      mask_q <= 1'b0;
    end
  end

  // Pending latch: a new check wins over the clear that releases an old one
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend_q      <= 1'b0;
      pend_id_q   <= 32'h0;
      pend_info_q <= 32'h0;
      pend_ctx_q  <= '0;
    end else if (check_event && (mask_q || state_q != mcst_pkg::MCST_IDLE) && !duplicate) begin
      pend_q      <= 1'b1;
      pend_id_q   <= check_error_id;
      pend_info_q <= check_info_valid ? check_info : `MCST_MISSING_CODE;
      pend_ctx_q  <= live_ctx;
    end else if (enter_d) begin
      pend_q <= 1'b0;
    end
  end

  // Status outputs registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      machine_check_mask          <= 1'b0;
      machine_check_handler_entry <= 1'b0;
      check_pending               <= 1'b0;
      in_handler                  <= 1'b0;
      at_firmware                 <= 1'b0;
      nested_check                <= 1'b0;
    end else begin
      machine_check_mask          <= mask_q || enter_d;
      machine_check_handler_entry <= enter_d;
      check_pending               <= pend_q;
      in_handler                  <= state_q == mcst_pkg::MCST_IN_HANDLER;
      at_firmware                 <= state_q == mcst_pkg::MCST_AT_FIRMWARE;
      nested_check                <= check_event && state_q != mcst_pkg::MCST_IDLE &&
                                     !duplicate;
    end
  end

  // Log at error time only; missing detail replaced by marker code
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      logged_error_id <= 32'h0;
      logged_info     <= 32'h0;
    end else if (enter_d && state_q != mcst_pkg::MCST_IDLE) begin
      logged_error_id <= pend_id_q;
      logged_info     <= pend_info_q;
    end else if (enter_d && check_event) begin
      logged_error_id <= check_error_id;
      logged_info     <= check_info_valid ? check_info : `MCST_MISSING_CODE;
    end
  end

  // Expected-check request is sticky until the next handler entry consumes it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      expected_q      <= 1'b0;
      recovery_enable <= 1'b0;
    end else if (enter_d) begin
      expected_q      <= expected_check_call;
      recovery_enable <= !(expected_q || expected_check_call);
    end else if (expected_check_call) begin
      expected_q <= 1'b1;
    end else if (state_q == mcst_pkg::MCST_IDLE) begin
      recovery_enable <= 1'b0;
    end
  end

  // Save area pointer written by firmware registration
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      save_area_pointer <= `MCST_PTR_RST;
    end else if (save_ptr_we) begin
      save_area_pointer <= save_ptr_wdata;
    end
  end

  // Recovery possible with collection on, or with both context copy and scratch registers present
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      recovery_ready <= 1'b0;
    end else begin
      recovery_ready <= interruption_collection_enable || (HAS_CTX_COPY && HAS_SCRATCH);
    end
  end

  // Context captured at entry; return pulse restores it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      check_ctx_copy <= '0;
      ctx_restore    <= 1'b0;
    end else begin
      ctx_restore <= HAS_CTX_COPY && ctx_return && state_q != mcst_pkg::MCST_IDLE;
      if (HAS_CTX_COPY && enter_d) begin
        check_ctx_copy <= (state_q != mcst_pkg::MCST_IDLE) ? pend_ctx_q : live_ctx;
      end
    end
  end

  // Three preserved scratch registers; never loaded when the option is off
  for (genvar i = 0; i < `MCST_SCRATCH_N; i++) begin : g_scr
    mcst_scratch_bank #(.W(64)) u_scr (
      .clk     (clk),
      .reset_n (reset_n),
      .load    (HAS_SCRATCH && scratch_we[i]),
      .din     (scratch_wdata),
      .dout    (check_scratch_regs[i*64 +: 64])
    );
  end

  // Entry raises the mask in the same cycle
  a_entry_sets_mask : assert property (@(posedge clk) disable iff (!reset_n)
    machine_check_handler_entry |-> machine_check_mask)
    else $error("mask not set at entry");
  a_masked_no_entry : assert property (@(posedge clk) disable iff (!reset_n)
    (check_event && mask_q && !mask_clear) |=> !machine_check_handler_entry)
    else $error("entry while masked");
  a_unmasked_entry : assert property (@(posedge clk) disable iff (!reset_n)
    (check_event && !mask_q && state_q == mcst_pkg::MCST_IDLE && !core_halted)
      |=> machine_check_handler_entry)
    else $error("no entry on unmasked check");
  a_pending_release : assert property (@(posedge clk) disable iff (!reset_n)
    (pend_q && mask_clear && state_q != mcst_pkg::MCST_IN_HANDLER && !core_halted)
      |=> machine_check_handler_entry)
    else $error("pending check not released");
  a_handler_mask_held : assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == mcst_pkg::MCST_IN_HANDLER) |-> mask_q)
    else $error("mask low in handler");
  a_untested_zero : assert property (@(posedge clk) disable iff (!reset_n)
    !result_word[`MCST_TESTED_BIT] |-> result_word == `MCST_RESULT_RST)
    else $error("fields set while untested");
  a_fp_disable_pair : assert property (@(posedge clk) disable iff (!reset_n)
    float_high_disable == float_low_disable && float_high_disable ==
      result_word[`MCST_FP_BIT])
    else $error("float disables mismatch");
  a_health_legal : assert property (@(posedge clk) disable iff (!reset_n)
    result_word[`MCST_HEALTH_MSB:`MCST_HEALTH_LSB] != 2'h3)
    else $error("illegal health code");
  a_halt_no_entry : assert property (@(posedge clk) disable iff (!reset_n)
    core_halted |=> !machine_check_handler_entry)
    else $error("entry after catastrophic halt");
  a_expected_no_recov : assert property (@(posedge clk) disable iff (!reset_n)
    (enter_d && expected_check_call) |=> !recovery_enable)
    else $error("recovery on expected check");
endmodule

// [tb/mcst_fw_model.sv]
// Behavioural platform firmware that hands off and later releases the check mask
`timescale 1ns/1ps
module mcst_fw_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       auto_en,
  input  wire logic [3:0] delay,
  input  wire logic       in_handler,
  input  wire logic       at_firmware,
  output logic            firmware_handoff,
  output logic            mask_clear
);
  logic [1:0] ph_q;
  logic [3:0] cnt_q;

  initial begin
    firmware_handoff = 1'b0;
    mask_clear       = 1'b0;
  end

  // Walks handler, firmware and release; never touches recovery registers
  always @(negedge clk) begin
    firmware_handoff <= 1'b0;
    mask_clear       <= 1'b0;
    if (!reset_n || !auto_en) begin
      ph_q  <= 2'h0;
      cnt_q <= 4'h0;
    end else begin
      case (ph_q)
        2'h0: if (in_handler) begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == delay) begin
            firmware_handoff <= 1'b1;
            ph_q             <= 2'h1;
            cnt_q            <= 4'h0;
          end
        end
        // Logging takes delay cycles; the mask stays set until it is done
        2'h1: if (at_firmware) begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == delay) begin
            mask_clear <= 1'b1;
            ph_q       <= 2'h2;
            cnt_q      <= 4'h0;
          end
        end
        default: if (!at_firmware) ph_q <= 2'h0;
      endcase
    end
  end
endmodule

// [tb/machine_check_selftest_status_tb.sv]
// Self-checking bench for self-test reporting and machine-check entry
`timescale 1ns/1ps
module machine_check_selftest_status_tb;
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  mcst_pkg::mcst_test_t test_in = '0, t;
  mcst_pkg::mcst_ctx_t  live_ctx = '0, check_ctx_copy;
  logic test_valid = 1'b0, check_event = 1'b0, check_info_valid = 1'b0;
  logic expected_check_call = 1'b0, exec_possible = 1'b1, save_ptr_we = 1'b0;
  logic ctx_return = 1'b0, interruption_collection_enable = 1'b1, auto_en = 1'b1;
  logic [31:0]  check_error_id = '0, check_info = '0, logged_error_id, logged_info;
  logic [63:0]  save_ptr_wdata = '0, scratch_wdata = '0, result_word, save_area_pointer;
  logic [2:0]   scratch_we = '0;
  logic [3:0]   delay = 4'h8;
  logic [4:0]   unit_isolate;
  logic [191:0] check_scratch_regs;
  logic firmware_handoff, mask_clear, core_halted, float_low_disable, float_high_disable;
  logic machine_check_mask, machine_check_handler_entry, check_pending, in_handler;
  logic at_firmware, recovery_enable, nested_check, ctx_restore, recovery_ready;
  logic f;
  bit   hit;
  int   miscompares = 0;
  int   checks_done = 0;

  always #2.5 clk = ~clk;

  mcst_core i_mcst_core (.clk(clk), .reset_n(reset_n), .test_in(test_in),
    .test_valid(test_valid), .check_event(check_event), .check_error_id(check_error_id),
    .check_info_valid(check_info_valid), .check_info(check_info), .live_ctx(live_ctx),
    .expected_check_call(expected_check_call), .mask_clear(mask_clear),
    .firmware_handoff(firmware_handoff), .exec_possible(exec_possible),
    .save_ptr_we(save_ptr_we), .save_ptr_wdata(save_ptr_wdata), .scratch_we(scratch_we),
    .scratch_wdata(scratch_wdata), .ctx_return(ctx_return),
    .interruption_collection_enable(interruption_collection_enable),
    .result_word(result_word), .core_halted(core_halted),
    .float_low_disable(float_low_disable), .float_high_disable(float_high_disable),
    .unit_isolate(unit_isolate), .machine_check_mask(machine_check_mask),
    .machine_check_handler_entry(machine_check_handler_entry),
    .check_pending(check_pending), .in_handler(in_handler), .at_firmware(at_firmware),
    .recovery_enable(recovery_enable), .logged_error_id(logged_error_id),
    .logged_info(logged_info), .nested_check(nested_check),
    .save_area_pointer(save_area_pointer), .check_ctx_copy(check_ctx_copy),
    .ctx_restore(ctx_restore), .check_scratch_regs(check_scratch_regs),
    .recovery_ready(recovery_ready));

  mcst_fw_model i_mcst_fw_model (.clk(clk), .reset_n(reset_n), .auto_en(auto_en),
    .delay(delay), .in_handler(in_handler), .at_firmware(at_firmware),
    .firmware_handoff(firmware_handoff), .mask_clear(mask_clear));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Bounded wait: 0 entry pulse, 1 at firmware, 2 idle and unmasked, 3 restore pulse
  task automatic wait_for(input int which, input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      // Look first: one-cycle pulses may already stand when the task is called
      case (which)
        0: hit = (machine_check_handler_entry === 1'b1);
        1: hit = (at_firmware === 1'b1);
        2: hit = (machine_check_mask === 1'b0 && in_handler === 1'b0 && at_firmware === 1'b0);
        default: hit = (ctx_restore === 1'b1);
      endcase
      if (!hit) @(negedge clk);
    end
    chk("wait_done", 1, hit);
  endtask

  // Drives one self-test outcome, held for one sampling edge
  task automatic post_test(input mcst_pkg::mcst_test_t v);
    @(negedge clk);
    test_in    = v;
    test_valid = 1'b1;
    @(negedge clk);
    test_valid = 1'b0;
    @(negedge clk);
  endtask

  // One machine-check error pulse; live state then moves on, as it would after the error
  task automatic fire(input logic [31:0] id, input logic iv, input logic [31:0] info);
    @(negedge clk);
    check_event      = 1'b1;
    check_error_id   = id;
    check_info_valid = iv;
    check_info       = info;
    @(negedge clk);
    check_event = 1'b0;
    live_ctx    = ~live_ctx;
  endtask

  initial begin
    #20000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    // Health codes, flags, layout and float disables over a table of outcomes
    for (int i = 0; i < 7; i++) begin
      t = '{done: 1'b1, catastrophic: 1'b0, perf_degraded: (i == 1 || i == 6),
            vm_fail: (i == 2 || i == 6), x86_fail: (i == 3 || i == 6),
            fp_fail: (i == 4 || i == 6), misc_fail: (i == 5 || i == 6),
            detail: (i == 0) ? 32'h0 : 32'h8000_1230 + i};
      f = t.vm_fail | t.x86_fail | t.fp_fail | t.misc_fail;
      post_test(t);
      chk("result_word", {t.detail, 12'h000, t.misc_fail, t.fp_fail, t.x86_fail, t.vm_fail,
          13'h0000, 1'b1, f ? 2'h2 : {1'b0, t.perf_degraded}}, result_word);
      chk("unit_isolate", {t.misc_fail, t.fp_fail, t.x86_fail, t.vm_fail, 1'b0}, unit_isolate);
      chk("float_disables", {2{t.fp_fail}}, {float_low_disable, float_high_disable});
    end
    t = '{done: 1'b0, perf_degraded: 1'b1, default: '0};
    post_test(t);
    chk("tested_flag", 0, result_word[2]);
    // Unmasked check: entry, mask, logging at error time, missing-info code
    live_ctx = '{ip: 64'h0000_4000_0000_0a10, status: 64'h11, frame: 64'h0000_0000_0000_0307};
    fire(32'h0000_0001, 1'b0, 32'h0);
    wait_for(0, 6);
    chk("mask_on_entry", 1, machine_check_mask);
    @(negedge clk);
    chk("log_id", 32'h0000_0001, logged_error_id);
    chk("log_missing", 32'hffff_ffff, logged_info);
    chk("ctx_ip", 64'h0000_4000_0000_0a10, check_ctx_copy.ip);
    chk("ctx_frame", 64'h0000_0000_0000_0307, check_ctx_copy.frame);
    chk("recovery", 1, recovery_enable);
    fire(32'h0000_0001, 1'b1, 32'h5);
    chk("dup_pending", 0, check_pending);
    chk("dup_nested", 0, nested_check);
    fire(32'h0000_0002, 1'b1, 32'h0000_00c7);
    chk("nested_flag", 1, nested_check);
    @(negedge clk);
    chk("nested_pending", 1, check_pending);
    chk("nested_in_handler", 1, in_handler);
    wait_for(1, 30);
    chk("mask_at_firmware", 1, machine_check_mask);
    wait_for(0, 40);
    @(negedge clk);
    chk("log_id2", 32'h0000_0002, logged_error_id);
    chk("log_info2", 32'h0000_00c7, logged_info);
    wait_for(2, 60);
    // Expected check: logged, no recovery
    delay = 4'h2;
    @(negedge clk);
    expected_check_call = 1'b1;
    @(negedge clk);
    expected_check_call = 1'b0;
    fire(32'h0000_0003, 1'b1, 32'h0000_0033);
    wait_for(0, 6);
    @(negedge clk);
    chk("expected_norecov", 0, recovery_enable);
    chk("expected_log", 32'h0000_0003, logged_error_id);
    wait_for(2, 40);
    // No firmware transfer while execution is impossible, then the retry succeeds
    exec_possible = 1'b0;
    fire(32'h0000_0005, 1'b1, 32'h0);
    wait_for(0, 6);
    repeat (10) @(negedge clk);
    chk("no_handoff", 0, at_firmware);
    // Restoring return is only meaningful while a check is being handled
    ctx_return = 1'b1;
    @(negedge clk);
    ctx_return = 1'b0;
    wait_for(3, 4);
    exec_possible = 1'b1;
    auto_en       = 1'b0;
    @(negedge clk);
    auto_en = 1'b1;
    wait_for(1, 20);
    wait_for(2, 40);
    // Recovery resources: save pointer, scratch bank, recovery ready
    @(negedge clk);
    save_ptr_we    = 1'b1;
    save_ptr_wdata = 64'h0000_0000_00fe_8000;
    @(negedge clk);
    save_ptr_we = 1'b0;
    for (int i = 0; i < 3; i++) begin
      scratch_we    = 3'h1 << i;
      scratch_wdata = 64'h5a5a_0000_0000_0000 + i;
      @(negedge clk);
    end
    scratch_we = 3'h0;
    @(negedge clk);
    chk("save_ptr", 64'h0000_0000_00fe_8000, save_area_pointer);
    chk("recovery_ready", 1, recovery_ready);
    for (int i = 0; i < 3; i++) begin
      chk("scratch", 64'h5a5a_0000_0000_0000 + i, check_scratch_regs[i*64 +: 64]);
    end
    // Catastrophic outcome halts and never reaches firmware
    t = '{done: 1'b1, catastrophic: 1'b1, default: '0};
    post_test(t);
    chk("halted", 1, core_halted);
    fire(32'h0000_0009, 1'b1, 32'h0);
    repeat (20) @(negedge clk);
    chk("halt_no_firmware", 0, {in_handler, at_firmware});
    conclude();
  end
endmodule
